// *** dv/psa_alu_sva.sv ***
`include "psa_regs.vh"
`default_nettype none
module psa_alu_chk (
   // Clock and reset
   input wire logic        sys_clk_i,
   input wire logic        resetn_i,
   // Request
   input wire logic        valid_i,
   input wire logic [4:0]  op_i,
   input wire logic [1:0]  form_i,
   input wire logic        byte_mode_i,
   input wire logic [5:0]  imm_i,
   input wire logic [31:0] src_a_i,
   input wire logic [31:0] src_b_i,
   input wire logic [31:0] dest_old_i,
   // Result
   input wire logic        valid_o,
   input wire logic [31:0] result_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] a_q, b_q, d_q;
   logic [5:0]  imm_q;
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!resetn_i);
   // Operands of the request seen at the last edge
   always_ff @(posedge sys_clk_i) begin
      a_q <= src_a_i;
      b_q <= src_b_i;
      d_q <= dest_old_i;
      imm_q <= imm_i;
   end
   // A request of one op, given form and lane mode
   sequence s_take(logic [4:0] op, logic [1:0] fm, logic bm);
      valid_i && op_i == op && form_i == fm && byte_mode_i == bm;
   endsequence
   property p_sum;
      s_take(`PSA_OP_SUM, `PSA_FORM_VEC, 1'b0) |=> valid_o &&
         result_o == {a_q[31:16] + b_q[31:16], a_q[15:0] + b_q[15:0]};
   endproperty
   a_sum: assert property (p_sum) else $error("halfword sum wrong");
   property p_diff;
      s_take(`PSA_OP_DIFF, `PSA_FORM_VEC, 1'b1) |=> result_o == {a_q[31:24] - b_q[31:24],
         a_q[23:16] - b_q[23:16], a_q[15:8] - b_q[15:8], a_q[7:0] - b_q[7:0]};
   endproperty
   a_diff: assert property (p_diff) else $error("byte difference wrong");
   property p_xor;
      s_take(`PSA_OP_XOR, `PSA_FORM_VEC, 1'b0) |=> result_o == (a_q ^ b_q);
   endproperty
   a_xor: assert property (p_xor) else $error("toggle wrong");
   property p_hjoin;
      s_take(`PSA_OP_HJOIN, `PSA_FORM_VEC, 1'b0) |=> result_o == {a_q[15:0], b_q[15:0]};
   endproperty
   a_hjoin: assert property (p_hjoin) else $error("half join wrong");
   property p_bjoin;
      s_take(`PSA_OP_BJOIN_LO, `PSA_FORM_VEC, 1'b0) |=>
         result_o == {d_q[31:16], a_q[7:0], b_q[7:0]};
   endproperty
   a_bjoin: assert property (p_bjoin) else $error("lower byte join wrong");
   property p_pull;
      s_take(`PSA_OP_PULL_U, `PSA_FORM_VEC, 1'b0) |=>
         result_o == {16'h0000, imm_q[0] ? a_q[31:16] : a_q[15:0]};
   endproperty
   a_pull: assert property (p_pull) else $error("unsigned pull wrong");
   property p_dota;
      s_take(`PSA_OP_DOTA_U, `PSA_FORM_VEC, 1'b0) |=> valid_o &&
         result_o == d_q + a_q[15:0] * b_q[15:0] + a_q[31:16] * b_q[31:16];
   endproperty
   a_dota: assert property (p_dota) else $error("accumulated dot wrong");
   property p_scalar;
      s_take(`PSA_OP_AND, `PSA_FORM_SCALAR, 1'b0) |=> result_o == (a_q & {2{b_q[15:0]}});
   endproperty
   a_scalar: assert property (p_scalar) else $error("scalar form wrong");
   property p_mean_u;
      s_take(`PSA_OP_MEAN_U, `PSA_FORM_VEC, 1'b0) |=>
         result_o[31:16] == (16'(a_q[31:16] + b_q[31:16]) >> 1) &&
         result_o[15:0] == (16'(a_q[15:0] + b_q[15:0]) >> 1);
   endproperty
   a_mean_u: assert property (p_mean_u) else $error("unsigned mean wrong");
   property p_idle;
      !valid_i |=> !valid_o && $stable(result_o);
   endproperty
   a_idle: assert property (p_idle) else $error("result moved without request");
endmodule
`default_nettype wire

// *** dv/psa_feed.sv ***
`default_nettype none
module psa_feed (
   // Clock
   input  wire logic        sys_clk_i,
   // Request towards the datapath
   output var  logic        valid_o,
   output var  logic [4:0]  op_o,
   output var  logic [1:0]  form_o,
   output var  logic        byte_o,
   output var  logic [5:0]  imm_o,
   output var  logic [31:0] a_o,
   output var  logic [31:0] b_o,
   output var  logic [31:0] d_o,
   // Answer from the datapath
   input  wire logic        ans_valid_i,
   input  wire logic [31:0] ans_i
);
   timeunit 1ns;
   timeprecision 1ps;
   initial {valid_o, op_o, form_o, byte_o, imm_o, a_o, b_o, d_o} = '0;
   // One request, answer taken in the cycle after; operands scrambled once released
   task automatic issue(input logic [4:0] op, input logic [1:0] fm, input logic bm,
                        input logic [5:0] imm, input logic [31:0] a, b, d,
                        output logic [31:0] r);
      @(posedge sys_clk_i);
      #1;
      {valid_o, op_o, form_o, byte_o, imm_o, a_o, b_o, d_o} = {1'b1, op, fm, bm, imm, a, b, d};
      @(posedge sys_clk_i);
      #1;
      valid_o = 1'b0;
      {a_o, b_o, d_o} = ~{a_o, b_o, d_o};
      r = (ans_valid_i === 1'b1) ? ans_i : 32'hXXXXXXXX;
   endtask
endmodule
`default_nettype wire

// *** dv/psa_tb.sv ***
`include "psa_regs.vh"
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        sys_clk, resetn, vi, vo, bm;
   logic [4:0]  op;
   logic [1:0]  fm;
   logic [5:0]  imm;
   logic [31:0] a, b, d, res;
   int          err_count, checked;
   localparam logic [2:0] H = 3'h0, B = 3'h1, SH = 3'h2, SB = 3'h3, IH = 3'h4;
   psa_feed u_feed (.sys_clk_i(sys_clk), .valid_o(vi), .op_o(op), .form_o(fm), .byte_o(bm),
      .imm_o(imm), .a_o(a), .b_o(b), .d_o(d), .ans_valid_i(vo), .ans_i(res));
   psa_alu DUT (.sys_clk_i(sys_clk), .resetn_i(resetn), .valid_i(vi), .op_i(op), .form_i(fm),
      .byte_mode_i(bm), .imm_i(imm), .src_a_i(a), .src_b_i(b), .dest_old_i(d),
      .valid_o(vo), .result_o(res));
   // Clock
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   // Compare one value
   task automatic check(input logic [31:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // One operation through the feeder, {form, byte mode} packed in f
   task automatic go(input logic [4:0] o, input logic [2:0] f, input logic [5:0] i,
                     input logic [31:0] x, y, z, exp);
      logic [31:0] r;
      u_feed.issue(o, f[2:1], f[0], i, x, y, z, r);
      check(r, exp);
   endtask
   task automatic t_arith;
      go(`PSA_OP_SUM, H, 6'h00, 32'h7FFFFFFF, 32'h00010001, 32'h0, 32'h80000000);
      go(`PSA_OP_DIFF, B, 6'h00, 32'h00010203, 32'h01010101, 32'h0, 32'hFF000102);
      go(`PSA_OP_MEAN_S, H, 6'h00, 32'h7FFF0004, 32'h0001FFFE, 32'h0, 32'hC0000001);
      go(`PSA_OP_MEAN_U, H, 6'h00, 32'h7FFF0004, 32'h0001FFFE, 32'h0, 32'h40000001);
      go(`PSA_OP_SMALL_S, H, 6'h00, 32'h80000005, 32'h00010003, 32'h0, 32'h80000003);
      go(`PSA_OP_SMALL_U, H, 6'h00, 32'h80000005, 32'h00010003, 32'h0, 32'h00010003);
      go(`PSA_OP_LARGE_S, H, 6'h00, 32'h80000005, 32'h00010003, 32'h0, 32'h00010005);
      go(`PSA_OP_LARGE_U, H, 6'h00, 32'h80000005, 32'h00010003, 32'h0, 32'h80000005);
   endtask
   task automatic t_bits;
      go(`PSA_OP_SRL, B, 6'h00, 32'h80F01001, 32'h01040207, 32'h0, 32'h400F0400);
      go(`PSA_OP_SRA, B, 6'h00, 32'h80F01001, 32'h01040207, 32'h0, 32'hC0FF0400);
      go(`PSA_OP_SLL, B, 6'h00, 32'h80F01001, 32'h01040207, 32'h0, 32'h00004080);
      go(`PSA_OP_OR, H, 6'h00, 32'hF0F000FF, 32'h0FF00F0F, 32'h0, 32'hFFF00FFF);
      go(`PSA_OP_XOR, H, 6'h00, 32'hF0F000FF, 32'h0FF00F0F, 32'h0, 32'hFF000FF0);
      go(`PSA_OP_AND, H, 6'h00, 32'hF0F000FF, 32'h0FF00F0F, 32'h0, 32'h00F0000F);
      go(`PSA_OP_MAG, B, 6'h00, 32'h80FF0105, 32'h0, 32'h0, 32'h80010105);
   endtask
   task automatic t_lane;
      go(`PSA_OP_PULL_S, B, 6'h02, 32'h12803456, 32'h0, 32'h0, 32'hFFFFFF80);
      go(`PSA_OP_PULL_U, B, 6'h02, 32'h12803456, 32'h0, 32'h0, 32'h00000080);
      go(`PSA_OP_PULL_U, H, 6'h01, 32'h12803456, 32'h0, 32'h0, 32'h00001280);
      go(`PSA_OP_PLACE, H, 6'h01, 32'h0000BEEF, 32'h0, 32'h11112222, 32'hBEEF2222);
      go(`PSA_OP_PLACE, B, 6'h03, 32'h000000EE, 32'h0, 32'h11223344, 32'hEE223344);
   endtask
   task automatic t_dot;
      go(`PSA_OP_DOT_U, H, 6'h00, 32'hFFFF0002, 32'hFFFF0003, 32'h0, 32'hFFFE0007);
      go(`PSA_OP_DOT_M, H, 6'h00, 32'hFFFF0002, 32'hFFFF0003, 32'h0, 32'hFFFF0007);
      go(`PSA_OP_DOT_S, H, 6'h00, 32'hFFFF0002, 32'hFFFF0003, 32'h0, 32'h00000007);
      go(`PSA_OP_DOTA_U, H, 6'h00, 32'hFFFF0002, 32'hFFFF0003, 32'h20000, 32'h7);
      go(`PSA_OP_DOTA_M, H, 6'h00, 32'hFFFF0002, 32'hFFFF0003, 32'h1, 32'hFFFF0008);
      go(`PSA_OP_DOTA_S, H, 6'h00, 32'hFFFF0002, 32'hFFFF0003, 32'hFFFFFFFF, 32'h6);
   endtask
   task automatic t_mix;
      go(`PSA_OP_PERM2, B, 6'h00, 32'h44332211, 32'h07000601, 32'hDDCCBBAA, 32'h44AA33BB);
      go(`PSA_OP_PERMI, B, 6'h06, 32'h44332211, 32'h2, 32'h0, 32'h33112233);
      go(`PSA_OP_PERMI, H, 6'h01, 32'h44332211, 32'h0, 32'h0, 32'h22114433);
      go(`PSA_OP_PERM, B, 6'h00, 32'h44332211, 32'h00010203, 32'h0, 32'h11223344);
      go(`PSA_OP_HJOIN, H, 6'h00, 32'h12345678, 32'h9ABCDEF0, 32'h0, 32'h5678DEF0);
      go(`PSA_OP_HJOIN_HI, H, 6'h00, 32'h12345678, 32'h9ABCDEF0, 32'h0, 32'h12349ABC);
      go(`PSA_OP_BJOIN_UP, H, 6'h00, 32'h12345678, 32'h9ABCDEF0, 32'hAAAAAAAA, 32'h78F0AAAA);
      go(`PSA_OP_BJOIN_LO, H, 6'h00, 32'h12345678, 32'h9ABCDEF0, 32'hAAAAAAAA, 32'hAAAA78F0);
      go(`PSA_OP_SUM, SB, 6'h00, 32'h01020304, 32'h00000005, 32'h0, 32'h06070809);
      go(`PSA_OP_AND, SH, 6'h00, 32'hFFFF0F0F, 32'h000000FF, 32'h0, 32'h00FF000F);
      go(`PSA_OP_SUM, IH, 6'h2A, 32'h00100020, 32'h0, 32'h0, 32'hFFFA000A);
      go(`PSA_OP_SMALL_U, IH, 6'h3F, 32'h00400010, 32'h0, 32'h0, 32'h003F0010);
   endtask
   // Closing report and end of run
   task automatic give_verdict;
      $display("Comparisons %0d, mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // Main sequence
   initial begin
      err_count = 0;
      checked = 0;
      resetn = 1'b0;
      repeat (12) @(posedge sys_clk);
      #1 resetn = 1'b1;
      t_arith();
      $display("arith done");
      t_bits();
      $display("bits done");
      t_lane();
      $display("lane done");
      t_dot();
      $display("dot done");
      t_mix();
      $display("mix done");
      give_verdict();
   end
endmodule
bind psa_alu psa_alu_chk u_chk (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .valid_i(valid_i),
   .op_i(op_i), .form_i(form_i), .byte_mode_i(byte_mode_i), .imm_i(imm_i),
   .src_a_i(src_a_i), .src_b_i(src_b_i), .dest_old_i(dest_old_i), .valid_o(valid_o),
   .result_o(result_o));
`default_nettype wire

// *** src/psa_alu.v ***
// Behaviour
// [RL1] Add or subtract each lane, truncated to lane width, no inter-lane carry.
// [RL2] Signed mean: truncated lane sum shifted right arithmetically by one.
// [RL3] Unsigned mean: truncated lane sum shifted right logically by one.
// [RL4] Minimum per lane; unsigned variant compares unsigned, immediate zero-extended.
// [RL5] Maximum per lane; unsigned variant compares lanes as unsigned.
// [RL6] Logical right shift per lane by second lane amount; immediate zero-extended.
// [RL7] Arithmetic right shift per lane, sign replicated; immediate zero-extended.
// [RL8] Left shift per lane, zero fill, result kept within the lane.
// [RL9] Lane-wise OR, XOR and AND of both operands.
// [RL10] Magnitude negates negative lanes of first operand, others unchanged.
// [RL11] Extract selected lane with sign or zero extension; insert low lane.
// [RL12] Dot product sums two halfword or four byte lane products.
// [RL13] Mixed-sign dot: first operand unsigned, second signed; unsigned: both unsigned.
// [RL14] Signed dot treats every lane of both operands as signed.
// [RL15] Accumulating dot adds old destination value to product sum.
// [RL16] Two-source permute picks lanes by index; select bit chooses first or old.
// [RL17] Immediate byte permute: bytes two..zero by bit pairs, top byte fixed; the code picks the top byte by second operand bits 1:0.
// [RL18] Half join packs low halves; high variant packs upper halves.
// [RL19] Byte join writes both low bytes into upper or lower pair.
// [RL20] Scalar form replicates lowest lane of second operand across lanes.
// [RL21] Immediate form replicates immediate, sign-extended unless zero extension.
// [RL22] Byte mode has four lanes, halfword two, lane zero least significant.
// [RL23] No overflow or carry indication is produced.
// [RL24] Signed minimum compares lanes as two's-complement values.
// [RL25] Dot totals truncate to 32 bits.
`include "psa_regs.vh"
`default_nettype none
module psa_alu #(
   parameter WIDTH = 32
) (
   // Clock and reset
   input  wire             sys_clk_i,
   input  wire             resetn_i,
   // Request
   input  wire             valid_i,
   input  wire [4:0]       op_i,
   input  wire [1:0]       form_i,
   input  wire             byte_mode_i,
   input  wire [5:0]       imm_i,
   input  wire [WIDTH-1:0] src_a_i,
   input  wire [WIDTH-1:0] src_b_i,
   input  wire [WIDTH-1:0] dest_old_i,
   // Result
   output reg              valid_o,
   output reg  [WIDTH-1:0] result_o
);

   reg  [31:0] opb;
   reg  [31:0] res;
   reg  [7:0]  ab;
   reg  [7:0]  bb;
   reg  [15:0] ah;
   reg  [15:0] bh;
   reg  [15:0] sh;
   reg  [7:0]  sb;
   reg  [31:0] dot;
   reg  [31:0] pick;
   reg         zext;
   reg         as;
   reg         bs;
   reg  [31:0] lane_res;
   reg  [31:0] pull_res;
   reg  [31:0] place_res;
   reg  [31:0] perm_res;
   reg  [31:0] permi_res;
   reg  [31:0] join_res;
   integer     i;
   integer     j;
   integer     k;

   // Operand extension helpers
   function [31:0] ext8;
      input [7:0] v;
      input       s;
      begin
         ext8 = {{24{s & v[7]}}, v};
      end
   endfunction

   function [31:0] ext16;
      input [15:0] v;
      input        s;
      begin
         ext16 = {{16{s & v[15]}}, v};
      end
   endfunction

   // One halfword lane operation
   function [15:0] lane16;
      input [4:0]  op;
      input [15:0] a;
      input [15:0] b;
      reg   [15:0] s;
      begin
         s = a + b;
         case (op)
            `PSA_OP_SUM:     lane16 = a + b;                              // RL1
            `PSA_OP_DIFF:    lane16 = a - b;                              // RL1
            `PSA_OP_MEAN_S:  lane16 = {s[15], s[15:1]};                   // RL2
            `PSA_OP_MEAN_U:  lane16 = {1'b0, s[15:1]};                    // RL3
            `PSA_OP_SMALL_S: lane16 = ($signed(a) < $signed(b)) ? a : b;  // RL24
            `PSA_OP_SMALL_U: lane16 = (a < b) ? a : b;                    // RL4
            `PSA_OP_LARGE_S: lane16 = ($signed(a) > $signed(b)) ? a : b;  // RL5
            `PSA_OP_LARGE_U: lane16 = (a > b) ? a : b;                    // RL5
            `PSA_OP_SRL:     lane16 = a >> b;                             // RL6
            `PSA_OP_SRA:     lane16 = $signed(a) >>> b;                   // RL7
            `PSA_OP_SLL:     lane16 = a << b;                             // RL8
            `PSA_OP_OR:      lane16 = a | b;                              // RL9
            `PSA_OP_XOR:     lane16 = a ^ b;                              // RL9
            `PSA_OP_AND:     lane16 = a & b;                              // RL9
            `PSA_OP_MAG:     lane16 = a[15] ? (16'h0000 - a) : a;         // RL10
            default:         lane16 = 16'h0000;
         endcase
      end
   endfunction

   // One byte lane operation
   function [7:0] lane8;
      input [4:0] op;
      input [7:0] a;
      input [7:0] b;
      reg   [7:0] s;
      begin
         s = a + b;
         case (op)
            `PSA_OP_SUM:     lane8 = a + b;                               // RL1
            `PSA_OP_DIFF:    lane8 = a - b;                               // RL1
            `PSA_OP_MEAN_S:  lane8 = {s[7], s[7:1]};                      // RL2
            `PSA_OP_MEAN_U:  lane8 = {1'b0, s[7:1]};                      // RL3
            `PSA_OP_SMALL_S: lane8 = ($signed(a) < $signed(b)) ? a : b;   // RL24
            `PSA_OP_SMALL_U: lane8 = (a < b) ? a : b;                     // RL4
            `PSA_OP_LARGE_S: lane8 = ($signed(a) > $signed(b)) ? a : b;   // RL5
            `PSA_OP_LARGE_U: lane8 = (a > b) ? a : b;                     // RL5
            `PSA_OP_SRL:     lane8 = a >> b;                              // RL6
            `PSA_OP_SRA:     lane8 = $signed(a) >>> b;                    // RL7
            `PSA_OP_SLL:     lane8 = a << b;                              // RL8
            `PSA_OP_OR:      lane8 = a | b;                               // RL9
            `PSA_OP_XOR:     lane8 = a ^ b;                               // RL9
            `PSA_OP_AND:     lane8 = a & b;                               // RL9
            `PSA_OP_MAG:     lane8 = a[7] ? (8'h00 - a) : a;              // RL10
            default:         lane8 = 8'h00;
         endcase
      end
   endfunction

   // Second operand vector: vector, replicated scalar or replicated immediate
   always @* begin
      zext = (op_i == `PSA_OP_SMALL_U) || (op_i == `PSA_OP_LARGE_U) ||
             (op_i == `PSA_OP_SRL) || (op_i == `PSA_OP_SRA) || (op_i == `PSA_OP_SLL);
      case (form_i)
         `PSA_FORM_SCALAR:
            opb = byte_mode_i ? {4{src_b_i[7:0]}} : {2{src_b_i[15:0]}};  // RL20
         `PSA_FORM_IMM:
            opb = byte_mode_i ? {4{{{2{~zext & imm_i[5]}}, imm_i}}}      // RL21
                              : {2{{{10{~zext & imm_i[5]}}, imm_i}}};    // RL4
         default:
            opb = src_b_i;
      endcase
   end

   // Lane-wise ALU, lane zero in the low bits; no carry leaves a lane
   always @* begin
      lane_res = 32'h0000_0000;
      ab       = 8'h00;
      bb       = 8'h00;
      ah       = 16'h0000;
      bh       = 16'h0000;
      if (byte_mode_i) begin
         for (i = 0; i < 4; i = i + 1) begin                              // RL22
            ab = src_a_i[i*8 +: 8];
            bb = opb[i*8 +: 8];
            lane_res[i*8 +: 8] = lane8(op_i, ab, bb);
         end
      end else begin
         for (i = 0; i < 2; i = i + 1) begin                              // RL22
            ah = src_a_i[i*16 +: 16];
            bh = opb[i*16 +: 16];
            lane_res[i*16 +: 16] = lane16(op_i, ah, bh);
         end
      end
   end

   // Signedness of each dot product operand
   always @* begin
      as = (op_i == `PSA_OP_DOT_S) || (op_i == `PSA_OP_DOTA_S);             // RL14
      bs = as || (op_i == `PSA_OP_DOT_M) || (op_i == `PSA_OP_DOTA_M);       // RL13
   end

   // Sum of lane products, kept to 32 bits so any carry out is dropped
   always @* begin
      dot = 32'h0000_0000;
      if (byte_mode_i) begin
         for (j = 0; j < 4; j = j + 1) begin
            dot = dot + ext8(src_a_i[j*8 +: 8], as) * ext8(opb[j*8 +: 8], bs);       // RL12
         end
      end else begin
         for (j = 0; j < 2; j = j + 1) begin
            dot = dot + ext16(src_a_i[j*16 +: 16], as) * ext16(opb[j*16 +: 16], bs); // RL25
         end
      end
   end

   // Lane pull with sign or zero extension
   always @* begin
      sh = imm_i[0] ? src_a_i[31:16] : src_a_i[15:0];
      sb = src_a_i[imm_i[1:0]*8 +: 8];
      if (byte_mode_i)
         pull_res = ext8(sb, op_i == `PSA_OP_PULL_S);                     // RL11
      else
         pull_res = ext16(sh, op_i == `PSA_OP_PULL_S);                    // RL11
   end

   // Lane place; the other destination bits keep their old value
   always @* begin
      place_res = dest_old_i;
      if (byte_mode_i)
         place_res[imm_i[1:0]*8 +: 8] = src_a_i[7:0];                     // RL11
      else
         place_res[imm_i[0]*16 +: 16] = src_a_i[15:0];                    // RL11
   end

   // Permute by index bits; the two-source form may take old destination lanes
   always @* begin
      perm_res = 32'h0000_0000;
      pick     = 32'h0000_0000;
      if (byte_mode_i) begin
         for (k = 0; k < 4; k = k + 1) begin
            pick = (op_i == `PSA_OP_PERM || src_b_i[k*8+2]) ? src_a_i : dest_old_i;  // RL16
            perm_res[k*8 +: 8] = pick[src_b_i[k*8 +: 2]*8 +: 8];
         end
      end else begin
         for (k = 0; k < 2; k = k + 1) begin
            pick = (op_i == `PSA_OP_PERM || src_b_i[k*16+1]) ? src_a_i : dest_old_i; // RL16
            perm_res[k*16 +: 16] = pick[src_b_i[k*16]*16 +: 16];
         end
      end
   end

   // Immediate permute; byte form picks its top byte by second operand bits 1:0
   always @* begin
      permi_res = 32'h0000_0000;
      if (byte_mode_i) begin
         permi_res[31:24] = src_a_i[src_b_i[1:0]*8 +: 8];                 // RL17
         permi_res[23:16] = src_a_i[imm_i[5:4]*8 +: 8];
         permi_res[15:8]  = src_a_i[imm_i[3:2]*8 +: 8];
         permi_res[7:0]   = src_a_i[imm_i[1:0]*8 +: 8];
      end else begin
         permi_res[31:16] = src_a_i[imm_i[1]*16 +: 16];                   // RL17
         permi_res[15:0]  = src_a_i[imm_i[0]*16 +: 16];
      end
   end

   // Half and byte joins
   always @* begin
      case (op_i)
         `PSA_OP_HJOIN:    join_res = {src_a_i[15:0], src_b_i[15:0]};     // RL18
         `PSA_OP_HJOIN_HI: join_res = {src_a_i[31:16], src_b_i[31:16]};   // RL18
         `PSA_OP_BJOIN_UP: join_res = {src_a_i[7:0], src_b_i[7:0], dest_old_i[15:0]}; // RL19
         default:          join_res = {dest_old_i[31:16], src_a_i[7:0], src_b_i[7:0]}; // RL19
      endcase
   end

   // Result selection per operation; unused codes give zero from the lane unit
   always @* begin
      case (op_i)
         `PSA_OP_PULL_S, `PSA_OP_PULL_U:
            res = pull_res;                                               // RL11
         `PSA_OP_PLACE:
            res = place_res;                                              // RL11
         `PSA_OP_DOT_U, `PSA_OP_DOT_M, `PSA_OP_DOT_S:
            res = dot;                                                    // RL12
         `PSA_OP_DOTA_U, `PSA_OP_DOTA_M, `PSA_OP_DOTA_S:
            res = dest_old_i + dot;                                       // RL15 RL25
         `PSA_OP_PERM, `PSA_OP_PERM2:
            res = perm_res;                                               // RL16
         `PSA_OP_PERMI:
            res = permi_res;                                              // RL17
         `PSA_OP_HJOIN, `PSA_OP_HJOIN_HI, `PSA_OP_BJOIN_UP, `PSA_OP_BJOIN_LO:
            res = join_res;                                               // RL18 RL19
         default:
            res = lane_res;
      endcase
   end

   // Valid flag follows each taken request by one cycle
   always @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         valid_o <= 1'b0;
      end else begin
         valid_o <= valid_i;
      end
   end

   // Result register holds the last answer; no carry or overflow flag is kept
   always @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         result_o <= 32'h0000_0000;
      end else if (valid_i) begin
         result_o <= res;                                                 // RL23
      end
   end

endmodule
`default_nettype wire

// *** src/psa_regs.vh ***
`ifndef PSA_REGS_VH
`define PSA_REGS_VH
// Operation codes
`define PSA_OP_SUM        5'h00
`define PSA_OP_DIFF       5'h01
`define PSA_OP_MEAN_S     5'h02
`define PSA_OP_MEAN_U     5'h03
`define PSA_OP_SMALL_S    5'h04
`define PSA_OP_SMALL_U    5'h05
`define PSA_OP_LARGE_S    5'h06
`define PSA_OP_LARGE_U    5'h07
`define PSA_OP_SRL        5'h08
`define PSA_OP_SRA        5'h09
`define PSA_OP_SLL        5'h0A
`define PSA_OP_OR         5'h0B
`define PSA_OP_XOR        5'h0C
`define PSA_OP_AND        5'h0D
`define PSA_OP_MAG        5'h0E
`define PSA_OP_PULL_S     5'h0F
`define PSA_OP_PULL_U     5'h10
`define PSA_OP_PLACE      5'h11
`define PSA_OP_DOT_U      5'h12
`define PSA_OP_DOT_M      5'h13
`define PSA_OP_DOT_S      5'h14
`define PSA_OP_DOTA_U     5'h15
`define PSA_OP_DOTA_M     5'h16
`define PSA_OP_DOTA_S     5'h17
`define PSA_OP_PERM       5'h18
`define PSA_OP_PERM2      5'h19
`define PSA_OP_PERMI      5'h1A
`define PSA_OP_HJOIN      5'h1B
`define PSA_OP_HJOIN_HI   5'h1C
`define PSA_OP_BJOIN_UP   5'h1D
`define PSA_OP_BJOIN_LO   5'h1E
// Operand forms
`define PSA_FORM_VEC      2'h0
`define PSA_FORM_SCALAR   2'h1
`define PSA_FORM_IMM      2'h2
// Fields
`define PSA_SEL_HI2       2'h1
`define PSA_SEL_HI3       2'h2
`endif
